/* File: core/soft_reset_map.svh */
// register offsets, field positions and reset values of the soft reset control bank
`ifndef SOFT_RESET_MAP_SVH
`define SOFT_RESET_MAP_SVH

// system-control block placement
`define SYSCTL_BASE_ADDR      32'h400F_E000
`define SYSCTL_BASE_HI        20'h400FE
`define SYSCTL_OFFSET_W       12

// register byte offsets inside the block
`define OFS_SOFT_RESET_TWO    12'h048
`define OFS_CAPABILITY_VIEW   12'h050
`define OFS_RESET_STATUS      12'h054

// reset values
`define RST_SOFT_RESET_TWO    32'h0000_0000
`define RST_RESET_STATUS      32'h0000_0000

// field positions of the reset control register
`define BIT_ETHER_PHY         30
`define BIT_ETHER_MAC         28
`define BIT_PORT_G            6
`define BIT_PORT_F            5
`define BIT_PORT_E            4
`define BIT_PORT_D            3
`define BIT_PORT_C            2
`define BIT_PORT_B            1
`define BIT_PORT_A            0

// writable bits: 30, 28 and 6:0, all others read zero
`define WRITABLE_MASK         32'h5000_007F

// status register: sticky flag for a write blocked by the capability mask
`define BIT_BLOCKED_WRITE     16

`endif

/* File: core/soft_reset_pkg.sv */
// types and helper functions shared by the soft reset control bank
package soft_reset_pkg;

	// register selected by the current bus address
	typedef enum logic [1:0] {
		SEL_NONE   = 2'h0,
		SEL_CTRL   = 2'h1,
		SEL_STATUS = 2'h3,
		SEL_CAP    = 2'h2
	} reg_sel_e;

	typedef logic [31:0] word_t;

	// expand four byte strobes into a 32-bit lane mask
	function automatic word_t lane_mask(input logic [3:0] strb);
		word_t m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// merge write data into a register under a bit mask
	function automatic word_t masked_merge(input word_t old_v, input word_t new_v,
	                                       input word_t mask);
		return (old_v & ~mask) | (new_v & mask);
	endfunction

endpackage

/* File: core/capability_latch.sv */
// captures the device capability word while system reset is asserted
`timescale 1ns/1ps
module capability_latch
	import soft_reset_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] capability_i,
	output logic      [WIDTH-1:0] capability_o
);

	// sampled on every rising clock edge during reset, frozen afterwards
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			capability_o <= capability_i;
		end
	end

endmodule

/* File: core/reset_drive_stage.sv */
// registers the per-peripheral reset requests onto the reset outputs
`timescale 1ns/1ps
module reset_drive_stage
	import soft_reset_pkg::*;
#(
	parameter int WIDTH = 9
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] hold_req_i,
	output logic      [WIDTH-1:0] hold_o
);

	// glitch-free reset lines, all released during system reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hold_o <= '0;
		end else begin
			hold_o <= hold_req_i;
		end
	end

endmodule

/* File: core/soft_reset_control_bank_two.sv */
// soft reset control bank two: APB register and peripheral reset outputs
//
// Function
// R1: register sits at offset 0x048 from block base 0x400FE000, 32 bits wide.
// R2: writes are masked by capability word four; absent peripherals never update.
// R3: register is read-write and resets to 0x00000000.
// R4: bit 30 drives the reset of Ethernet PHY unit 0.
// R5: bit 28 drives the reset of Ethernet MAC unit 0.
// R6: bits 6 to 0 reset ports G down to A, bit 0 is port A.
// R7: bits 31, 29, 27:7 read zero; software preserves them on updates.
// R8: a bit at one holds its peripheral in reset; zero releases it.
`include "soft_reset_map.svh"
`timescale 1ns/1ps
module soft_reset_control_bank_two
	import soft_reset_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic [31:0] paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// device capability word four
	input  wire logic [31:0] capability_mask_four_i,
	// peripheral reset outputs, active high
	output logic             ether_phy_reset_o,
	output logic             ether_mac_reset_o,
	output logic             port_a_reset_o,
	output logic             port_b_reset_o,
	output logic             port_c_reset_o,
	output logic             port_d_reset_o,
	output logic             port_e_reset_o,
	output logic             port_f_reset_o,
	output logic             port_g_reset_o
);

	localparam int N_PERIPH = 9;

	word_t                soft_reset_ctrl_two;
	word_t                next_soft_reset_ctrl_two;
	word_t                capability_mask_four;
	word_t                write_mask;
	word_t                blocked_bits;
	word_t                read_value;
	word_t                status_word;
	logic                 blocked_write;
	logic                 next_blocked_write;
	logic                 blocked_clear;
	logic                 base_hit;
	reg_sel_e             sel;
	logic                 setup_phase;
	logic                 access_phase;
	logic                 ctrl_write;
	logic                 status_write;
	logic                 bad_access;
	logic [N_PERIPH-1:0]  hold_req;
	logic [N_PERIPH-1:0]  hold;

	// capability word caught during system reset
	capability_latch #(
		.WIDTH(32)
	) u_cap (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.capability_i (capability_mask_four_i),
		.capability_o (capability_mask_four)
	);

	// bus phases
	assign setup_phase  = psel_i & ~penable_i;
	assign access_phase = psel_i & penable_i;

	// zero wait state: every access completes in its first access cycle
	assign pready_o = access_phase;

	// block base and register decode
	assign base_hit = (paddr_i[31:`SYSCTL_OFFSET_W] == `SYSCTL_BASE_HI); // R1

	always_comb begin
		sel = SEL_NONE;
		if (base_hit && (paddr_i[1:0] == 2'h0)) begin
			case (paddr_i[`SYSCTL_OFFSET_W-1:0])
				`OFS_SOFT_RESET_TWO:  sel = SEL_CTRL; // R1
				`OFS_CAPABILITY_VIEW: sel = SEL_CAP;
				`OFS_RESET_STATUS:    sel = SEL_STATUS;
				default:              sel = SEL_NONE;
			endcase
		end
	end

	// unmapped address, or write to the read-only capability view
	assign bad_access = (sel == SEL_NONE) || ((sel == SEL_CAP) && pwrite_i);

	// write strobes, taken at the access edge only
	assign ctrl_write   = access_phase & pwrite_i & (sel == SEL_CTRL);
	assign status_write = access_phase & pwrite_i & (sel == SEL_STATUS);

	// bits that may change: byte lanes, writable field and capability
	assign write_mask = lane_mask(pstrb_i) & `WRITABLE_MASK & capability_mask_four; // R2 R7

	// bits software tried to set that the capability mask blocked
	assign blocked_bits = lane_mask(pstrb_i) & `WRITABLE_MASK & ~capability_mask_four
	                      & pwdata_i;

	// next value of the reset control register
	always_comb begin
		next_soft_reset_ctrl_two = soft_reset_ctrl_two;
		if (ctrl_write) begin
			next_soft_reset_ctrl_two = masked_merge(soft_reset_ctrl_two, pwdata_i,
			                                        write_mask); // R2
		end
	end

	// reset control register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			soft_reset_ctrl_two <= `RST_SOFT_RESET_TWO; // R3
		end else begin
			soft_reset_ctrl_two <= next_soft_reset_ctrl_two & `WRITABLE_MASK; // R7
		end
	end

	// write-one-to-clear of the blocked-write flag
	assign blocked_clear = status_write & pstrb_i[2] & pwdata_i[`BIT_BLOCKED_WRITE];

	// sticky flag: a new blocked write wins over a clear in the same cycle
	always_comb begin
		next_blocked_write = blocked_write;
		if (blocked_clear) begin
			next_blocked_write = 1'b0;
		end
		if (ctrl_write && (blocked_bits != 32'h0000_0000)) begin
			next_blocked_write = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			blocked_write <= 1'b0;
		end else begin
			blocked_write <= next_blocked_write;
		end
	end

	// gather the request bits of every peripheral
	assign hold_req = {
		soft_reset_ctrl_two[`BIT_ETHER_PHY], // R4
		soft_reset_ctrl_two[`BIT_ETHER_MAC], // R5
		soft_reset_ctrl_two[`BIT_PORT_G:`BIT_PORT_A] // R6
	};

	// registered reset lines toward the peripherals
	reset_drive_stage #(
		.WIDTH(N_PERIPH)
	) u_drive (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.hold_req_i (hold_req),
		.hold_o     (hold)
	);

	// reset outputs follow the register one cycle later
	assign ether_phy_reset_o = hold[8]; // R4 R8
	assign ether_mac_reset_o = hold[7]; // R5 R8
	assign port_g_reset_o    = hold[6]; // R6 R8
	assign port_f_reset_o    = hold[5]; // R6 R8
	assign port_e_reset_o    = hold[4]; // R6 R8
	assign port_d_reset_o    = hold[3]; // R6 R8
	assign port_c_reset_o    = hold[2]; // R6 R8
	assign port_b_reset_o    = hold[1]; // R6 R8
	assign port_a_reset_o    = hold[0]; // R6 R8

	// status word: peripherals really held in reset, plus blocked flag
	always_comb begin
		status_word = `RST_RESET_STATUS;
		status_word[`BIT_ETHER_PHY] = hold[8];
		status_word[`BIT_ETHER_MAC] = hold[7];
		status_word[`BIT_PORT_G:`BIT_PORT_A] = hold[6:0];
		status_word[`BIT_BLOCKED_WRITE] = blocked_write;
	end

	// read multiplexer, unused bits read zero
	always_comb begin
		case (sel)
			SEL_CTRL:   read_value = soft_reset_ctrl_two & `WRITABLE_MASK; // R3 R7
			SEL_CAP:    read_value = capability_mask_four;
			SEL_STATUS: read_value = status_word;
			default:    read_value = 32'h0000_0000;
		endcase
	end

	// read data and error captured in the setup cycle, held in access
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_o  <= pwrite_i ? 32'h0000_0000 : read_value;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pslverr_o <= 1'b0;
		end else if (setup_phase) begin
			pslverr_o <= bad_access;
		end else if (!psel_i) begin
			pslverr_o <= 1'b0;
		end
	end

endmodule

/* File: bench/soft_reset_control_bank_two_props.sv */
// concurrent checks on the soft reset control bank two ports
`timescale 1ns/1ps
module soft_reset_control_bank_two_props (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic [31:0] paddr_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [31:0] capability_mask_four_i,
	input wire logic        ether_phy_reset_o,
	input wire logic        ether_mac_reset_o,
	input wire logic        port_a_reset_o,
	input wire logic        port_b_reset_o,
	input wire logic        port_c_reset_o,
	input wire logic        port_d_reset_o,
	input wire logic        port_e_reset_o,
	input wire logic        port_f_reset_o,
	input wire logic        port_g_reset_o
);
	// output and capability vectors, access decode
	wire logic [8:0] rv = {ether_phy_reset_o, ether_mac_reset_o, port_g_reset_o, port_f_reset_o,
		port_e_reset_o, port_d_reset_o, port_c_reset_o, port_b_reset_o, port_a_reset_o};
	wire logic [31:0] cm = capability_mask_four_i;
	wire logic acc = psel_i && penable_i && paddr_i == 32'h400F_E048;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// write with the low byte lane enabled
	sequence s_wr0; acc && pwrite_i && pstrb_i[0]; endsequence
	property p_ready; psel_i && penable_i |-> pready_o; endproperty
	a_ready: assert property (p_ready) else $error("no ready in access");
	property p_rst; $past(rst_i) |-> rv == 9'h000 && prdata_o == 32'h0000_0000; endproperty
	a_rst: assert property (p_rst) else $error("not cleared by reset");
	property p_mask; (rv & ~{cm[30], cm[28], cm[6:0]}) == 9'h000; endproperty
	a_mask: assert property (p_mask) else $error("absent unit held");
	property p_phy; acc && pwrite_i && pstrb_i[3] |-> ##2
		ether_phy_reset_o == $past(pwdata_i[30] && cm[30], 2); endproperty
	a_phy: assert property (p_phy) else $error("phy reset wrong");
	property p_mac; acc && pwrite_i && pstrb_i[3] |-> ##2
		ether_mac_reset_o == $past(pwdata_i[28] && cm[28], 2); endproperty
	a_mac: assert property (p_mac) else $error("mac reset wrong");
	property p_port; s_wr0 |-> ##2 rv[6:0] == $past(pwdata_i[6:0] & cm[6:0], 2); endproperty
	a_port: assert property (p_port) else $error("port reset wrong");
	property p_read; acc && !pwrite_i |-> prdata_o == {1'b0, rv[8], 1'b0, rv[7], 21'h0, rv[6:0]};
	endproperty
	a_read: assert property (p_read) else $error("readback wrong");
	property p_hold; $changed(rv) |-> $past(acc && pwrite_i, 2); endproperty
	a_hold: assert property (p_hold) else $error("reset output moved");
endmodule

bind soft_reset_control_bank_two soft_reset_control_bank_two_props u_props (.ref_clk_i, .rst_i,
	.paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
	.pslverr_o, .capability_mask_four_i, .ether_phy_reset_o, .ether_mac_reset_o, .port_a_reset_o,
	.port_b_reset_o, .port_c_reset_o, .port_d_reset_o, .port_e_reset_o, .port_f_reset_o,
	.port_g_reset_o);

/* File: bench/soft_reset_control_bank_two_tb.sv */
// self-checking bench for the soft reset control bank two
`timescale 1ns/1ps
module soft_reset_control_bank_two_tb;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, cap, rd;
	logic [3:0]  pstrb;
	logic [8:0]  outs;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cyc = 0;
	// rows: write data, strobes, expected readback
	logic [67:0] rows [5] = '{{32'hFFFF_FFFF, 4'hF, 32'h5000_005F},
		{32'h0000_0000, 4'hF, 32'h0000_0000}, {32'h4000_0001, 4'hF, 32'h4000_0001},
		{32'h1000_0040, 4'h8, 32'h1000_0001}, {32'hAFFF_FF80, 4'hF, 32'h0000_0000}};

	soft_reset_control_bank_two dut (.ref_clk_i(clk), .rst_i(rst), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.capability_mask_four_i(cap), .ether_phy_reset_o(outs[8]), .ether_mac_reset_o(outs[7]),
		.port_a_reset_o(outs[0]), .port_b_reset_o(outs[1]), .port_c_reset_o(outs[2]),
		.port_d_reset_o(outs[3]), .port_e_reset_o(outs[4]), .port_f_reset_o(outs[5]),
		.port_g_reset_o(outs[6]));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test;
		if (mismatches == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer, request left up for a back-to-back follower
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
	endtask

	task automatic do_rst(input logic [31:0] c);
		psel <= 1'b0;
		penable <= 1'b0;
		rst <= 1'b1;
		cap <= c;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	// main sequence
	initial begin
		{pwrite, paddr, pwdata, pstrb} <= '0;
		do_rst(32'hFFFF_FFDF);
		foreach (rows[i]) begin
			apb(1'b1, 32'h400F_E048, rows[i][67:36], rows[i][35:32]);
			apb(1'b0, 32'h400F_E048, 32'h0, 4'h0);
			chk("ctrl", rd, rows[i][31:0]);
			chk("outs", {23'h0, outs}, {23'h0, rows[i][30], rows[i][28], rows[i][6:0]});
		end
		apb(1'b0, 32'h400F_E04C, 32'h0, 4'h0);
		chk("err", {31'h0, er}, 32'h1);
		chk("rd", rd, 32'h0);
		apb(1'b1, 32'h400F_F048, 32'hFFFF_FFFF, 4'hF);
		chk("err", {31'h0, er}, 32'h1);
		apb(1'b0, 32'h400F_E048, 32'h0, 4'h0);
		chk("ctrl", rd, 32'h0);
		chk("ok", {31'h0, er}, 32'h0);
		apb(1'b1, 32'h400F_E048, 32'hFFFF_FFFF, 4'hF);
		do_rst(32'h4000_0000);
		apb(1'b0, 32'h400F_E048, 32'h0, 4'h0);
		chk("rst", rd, 32'h0);
		chk("rst_outs", {23'h0, outs}, 32'h0);
		apb(1'b1, 32'h400F_E048, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, 32'h400F_E048, 32'h0, 4'h0);
		chk("cap", rd, 32'h4000_0000);
		chk("outs", {23'h0, outs}, 32'h100);
		// status: output levels plus blocked-write flag, then clear it
		apb(1'b0, 32'h400F_E054, 32'h0, 4'h0);
		chk("status", rd, 32'h4001_0000);
		apb(1'b1, 32'h400F_E054, 32'h0001_0000, 4'h4);
		apb(1'b0, 32'h400F_E054, 32'h0, 4'h0);
		chk("status", rd, 32'h4000_0000);
		// capability view is read-only
		apb(1'b0, 32'h400F_E050, 32'h0, 4'h0);
		chk("capview", rd, 32'h4000_0000);
		apb(1'b1, 32'h400F_E050, 32'h0, 4'hF);
		chk("caperr", {31'h0, er}, 32'h1);
		stop_test();
	end
endmodule
